// ### verilog/sfr_device.sv
// Flash device end: command sequencer, read array and protection state
`timescale 1ns/1ps
`default_nettype none
module sfr_device #(
	parameter int ADDR_W = 22
) (
	// Clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              nrst_in,
	// Serial link
	sfr_link_if.dev                lk,
	// Array preload
	input  wire logic              load_we_in,
	input  wire logic [ADDR_W-1:0] load_addr_in,
	input  wire logic [7:0]        load_data_in,
	// Status inputs
	input  wire logic              write_in_progress_flag_in,
	input  wire logic              protect_lock_bit_in,
	input  wire logic              quad_enable_bit_in,
	input  wire logic              dummy_count_select_in,
	input  wire logic              wel_clear_in,
	// Status outputs
	output logic                   write_enable_latch_out,
	output logic                   hardware_protection_out,
	output logic                   software_protection_out,
	output logic                   status_write_allowed_out,
	output logic                   busy_rejected_out
);
	// ************************************************
	// Types and storage
	// ************************************************
	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_CMD   = 6'h02,
		S_ADDR  = 6'h04,
		S_DUMMY = 6'h08,
		S_DATA  = 6'h10,
		S_SKIP  = 6'h20
	} sfr_dev_state_t;

	localparam int DEPTH = 1 << ADDR_W;

	logic [7:0]           mem [0:DEPTH-1];
	sfr_dev_state_t       state_reg;
	sfr_pkg::sfr_cmd_t    cmd_reg;
	sfr_pkg::sfr_cmd_t    dec;
	logic [7:0]           op_next;
	logic [23:0]          addr_sh_next;
	logic [7:0]           op_sh_reg;
	logic [23:0]          addr_sh_reg;
	logic [4:0]           cnt_reg;
	logic [ADDR_W-1:0]    addr_reg;
	logic [7:0]           out_sh_reg;
	logic [2:0]           bit_cnt_reg;
	logic                 write_enable_cmd_seen;
	logic                 reject_seen;
	logic                 data_start;
	logic                 cs_high;
	logic                 sclk_rise;
	logic                 sclk_fall;
	logic [3:0]           io_s;
	logic [5:0]           sync_level;
	logic [5:0]           sync_rise;
	logic [5:0]           sync_fall;

	// ************************************************
	// Link input synchronisation
	// ************************************************
	sfr_sync_edge #(
		.W(6)
	) u_sync (
		.core_clk_in(core_clk_in),
		.nrst_in    (nrst_in),
		.async_in   ({lk.cs_n, lk.sclk, lk.io_level}),
		.level_out  (sync_level),
		.rise_out   (sync_rise),
		.fall_out   (sync_fall)
	);

	assign cs_high   = sync_level[5];
	assign sclk_rise = sync_rise[4] & ~cs_high;
	assign sclk_fall = sync_fall[4] & ~cs_high;
	assign io_s      = sync_level[3:0];

	// ************************************************
	// Command decode
	// ************************************************
	always_comb begin
		op_next      = {op_sh_reg[6:0], io_s[0]};
		addr_sh_next = sfr_pkg::sfr_shift_in(addr_sh_reg, io_s, cmd_reg.addr_lw, 1'b0);
		dec          = sfr_pkg::sfr_decode(op_next, dummy_count_select_in);
		write_enable_cmd_seen    = 1'b0;
		reject_seen  = 1'b0;
		if (state_reg == S_CMD && sclk_rise && cnt_reg == 5'h00) begin
			write_enable_cmd_seen = (op_next == sfr_pkg::OP_WRITE_ENABLE_CMD);
			// Reads that would disturb an internal cycle are dropped and reported on busy_rejected_out
			reject_seen = dec.ok && dec.busy_reject && write_in_progress_flag_in;
		end
	end

	// Unmapped or unenabled commands run out the frame in S_SKIP
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg   <= S_IDLE;
			cmd_reg     <= '0;
			op_sh_reg   <= 8'h00;
			addr_sh_reg <= 24'h000000;
			cnt_reg     <= 5'h00;
		end else if (cs_high) begin
			state_reg <= S_IDLE;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					state_reg <= S_CMD;
					cnt_reg   <= sfr_pkg::CMD_BITS - 5'h01;
				end
				S_CMD: if (sclk_rise) begin
					op_sh_reg <= op_next;
					cnt_reg   <= cnt_reg - 5'h01;
					if (cnt_reg == 5'h00) begin
						cmd_reg <= dec;
						cnt_reg <= sfr_pkg::sfr_cycles(dec.addr_lw, sfr_pkg::ADDR_BITS) - 5'h01;
						if (!dec.ok || reject_seen || (dec.needs_qe && !quad_enable_bit_in)) begin
							state_reg <= S_SKIP;
						end else begin
							state_reg <= S_ADDR;
						end
					end
				end
				S_ADDR: if (sclk_rise) begin
					addr_sh_reg <= addr_sh_next;
					cnt_reg     <= cnt_reg - 5'h01;
					if (cnt_reg == 5'h00) begin
						cnt_reg   <= {1'b0, cmd_reg.dummy} - 5'h01;
						state_reg <= (cmd_reg.dummy == 4'h0) ? S_DATA : S_DUMMY;
					end
				end
				S_DUMMY: if (sclk_rise) begin
					cnt_reg <= cnt_reg - 5'h01;
					if (cnt_reg == 5'h00) begin
						state_reg <= S_DATA;
					end
				end
				S_DATA: state_reg <= S_DATA;
				S_SKIP: state_reg <= S_SKIP;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	assign data_start = (state_reg == S_ADDR) && sclk_rise && (cnt_reg == 5'h00);

	// ************************************************
	// Array and read data path
	// ************************************************
	always_ff @(posedge core_clk_in) begin
		if (load_we_in) begin
			mem[load_addr_in] <= load_data_in;
		end
	end

	// Each fall shifts out one beat; a new byte is fetched when the last beat left
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_reg    <= '0;
			out_sh_reg  <= 8'h00;
			bit_cnt_reg <= 3'h0;
			lk.dev_io   <= 4'h0;
			lk.dev_oe_n <= 4'hF;
		end else if (cs_high || state_reg != S_DATA) begin
			lk.dev_oe_n <= 4'hF;
			bit_cnt_reg <= 3'h0;
			if (data_start) begin
				addr_reg <= addr_sh_next[ADDR_W-1:0];
			end
		end else if (sclk_fall) begin
			if (bit_cnt_reg == 3'h0) begin
				addr_reg    <= addr_reg + 1'b1;
				bit_cnt_reg <= 3'(sfr_pkg::sfr_cycles(cmd_reg.data_lw, sfr_pkg::BYTE_BITS) - 5'h01);
				out_sh_reg  <= mem[addr_reg] << (4'h1 << cmd_reg.data_lw);
				lk.dev_io   <= drive_beat(mem[addr_reg], cmd_reg.data_lw);
			end else begin
				bit_cnt_reg <= bit_cnt_reg - 3'h1;
				out_sh_reg  <= out_sh_reg << (4'h1 << cmd_reg.data_lw);
				lk.dev_io   <= drive_beat(out_sh_reg, cmd_reg.data_lw);
			end
			lk.dev_oe_n <= (cmd_reg.data_lw == 2'h0) ? 4'hD : ~sfr_pkg::sfr_lanes(cmd_reg.data_lw);
		end
	end

	// Single-line data leaves on io1; wider data puts the high bit on the top line
	function automatic logic [3:0] drive_beat(input logic [7:0] b, input logic [1:0] lw);
		case (lw)
			2'h0: return {2'h0, b[7], 1'b0};
			2'h1: return {2'h0, b[7:6]};
			default: return b[7:4];
		endcase
	endfunction

	// ************************************************
	// Protection state and write enable latch
	// ************************************************
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			write_enable_latch_out <= 1'b0;
		end else if (write_enable_cmd_seen) begin
			// Set wins over a clear in the same cycle; allowed in every mode
			write_enable_latch_out <= 1'b1;
		end else if (wel_clear_in) begin
			write_enable_latch_out <= 1'b0;
		end
	end

	// The pin is io2, so with quad enabled it carries data and cannot protect
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hardware_protection_out  <= 1'b0;
			software_protection_out  <= 1'b1;
			status_write_allowed_out <= 1'b0;
			busy_rejected_out        <= 1'b0;
		end else begin
			hardware_protection_out  <= protect_lock_bit_in && !io_s[2] && !quad_enable_bit_in;
			software_protection_out  <= !(protect_lock_bit_in && !io_s[2] && !quad_enable_bit_in);
			status_write_allowed_out <= write_enable_latch_out &&
				!(protect_lock_bit_in && !io_s[2] && !quad_enable_bit_in);
			busy_rejected_out        <= reject_seen;
		end
	end
endmodule
`default_nettype wire

// ### verilog/sfr_pkg.sv
// Shared constants, command decode and helpers for the serial flash read link
//
// Summary of operation
// - Lock clear: latch settable, protect bits writable
// - Lock set, pin high: software protection
// - Lock set, pin low: hardware protection
// - Pin high leaves hardware protection
// - Quad enabled disables hardware protection
// - Sample on rising, shift out falling
// - Address increments per byte, wraps to zero
// - Host sends opcode, 3-byte address serially
// - Fast read: address, one dummy byte
// - Busy rejects fast, dual, quad-output reads
// - Dual-output read: 8 dummies, two lines
// - Dual I/O read: address two lines
// - Host holds non-toggling first two dummies
// - Host sets quad enable before quad
// - Quad-output read: 8 dummies, four lines
// - Quad I/O read: address four lines
// - Dummy select picks 4/8 or 6/10
// - Busy also rejects quad I/O read
`default_nettype none
package sfr_pkg;

	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_DOUT = 8'h3B;
	localparam logic [7:0] OP_DIO  = 8'hBB;
	localparam logic [7:0] OP_QOUT = 8'h6B;
	localparam logic [7:0] OP_QIO  = 8'hEB;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;

	localparam logic [4:0] CMD_BITS  = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [4:0] BYTE_BITS = 5'h08;

	localparam logic [3:0] DUMMY_FAST  = 4'h8;
	localparam logic [3:0] DUMMY_DOUT  = 4'h8;
	localparam logic [3:0] DUMMY_QOUT  = 4'h8;
	localparam logic [3:0] DUMMY_DIO_0 = 4'h4;
	localparam logic [3:0] DUMMY_DIO_1 = 4'h8;
	localparam logic [3:0] DUMMY_QIO_0 = 4'h6;
	localparam logic [3:0] DUMMY_QIO_1 = 4'hA;
	localparam logic [3:0] DUMMY_HELD  = 4'h2;

	localparam int CORE_CLK_NS      = 10;
	localparam int SCLK_PERIOD_NS   = 160;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CORE_CLK_NS);

	typedef struct packed {
		logic       ok;
		logic [1:0] addr_lw;
		logic [3:0] dummy;
		logic [1:0] data_lw;
		logic       needs_qe;
		logic       busy_reject;
	} sfr_cmd_t;

	// Lane width is kept as log2: 0 one line, 1 two lines, 2 four lines
	function automatic sfr_cmd_t sfr_decode(input logic [7:0] op, input logic dc);
		sfr_cmd_t c;
		c = '0;
		c.ok = 1'b1;
		case (op)
			OP_READ: c.dummy = 4'h0;
			OP_FAST: begin c.dummy = DUMMY_FAST; c.busy_reject = 1'b1; end
			OP_DOUT: begin c.dummy = DUMMY_DOUT; c.data_lw = 2'h1; c.busy_reject = 1'b1; end
			OP_DIO: begin
				c.addr_lw = 2'h1;
				c.data_lw = 2'h1;
				c.dummy = dc ? DUMMY_DIO_1 : DUMMY_DIO_0;
				c.busy_reject = 1'b1;
			end
			OP_QOUT: begin
				c.dummy = DUMMY_QOUT;
				c.data_lw = 2'h2;
				c.needs_qe = 1'b1;
				c.busy_reject = 1'b1;
			end
			OP_QIO: begin
				c.addr_lw = 2'h2;
				c.data_lw = 2'h2;
				c.dummy = dc ? DUMMY_QIO_1 : DUMMY_QIO_0;
				c.needs_qe = 1'b1;
				c.busy_reject = 1'b1;
			end
			default: c.ok = 1'b0;
		endcase
		return c;
	endfunction

	function automatic logic [4:0] sfr_cycles(input logic [1:0] lw, input logic [4:0] bits);
		return bits >> lw;
	endfunction

	function automatic logic [3:0] sfr_lanes(input logic [1:0] lw);
		return (lw == 2'h0) ? 4'h1 : (lw == 2'h1) ? 4'h3 : 4'hF;
	endfunction

	// Shifts one clock worth of line bits in; single-line data comes on io1 or io0
	function automatic logic [23:0] sfr_shift_in(input logic [23:0] v, input logic [3:0] io,
			input logic [1:0] lw, input logic use_io1);
		case (lw)
			2'h0: return {v[22:0], use_io1 ? io[1] : io[0]};
			2'h1: return {v[21:0], io[1:0]};
			default: return {v[19:0], io};
		endcase
	endfunction

endpackage
`default_nettype wire

// ### verilog/sfr_link_if.sv
// Serial link between the flash device end and the host end
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
	logic       sclk;
	logic       cs_n;
	logic [3:0] host_io;
	logic [3:0] host_oe_n;
	logic [3:0] dev_io;
	logic [3:0] dev_oe_n;
	logic [3:0] io_level;

	// Lines float high when nobody drives them; host wins a clash
	assign io_level = (~host_oe_n & host_io) | (host_oe_n & ~dev_oe_n & dev_io) | (host_oe_n & dev_oe_n);

	modport host (
		output sclk,
		output cs_n,
		output host_io,
		output host_oe_n,
		input  io_level
	);

	modport dev (
		input  sclk,
		input  cs_n,
		output dev_io,
		output dev_oe_n,
		input  io_level
	);
endinterface
`default_nettype wire

// ### verilog/sfr_sync_edge.sv
// Two-stage synchroniser with edge pulses taken after the second stage
`timescale 1ns/1ps
`default_nettype none
module sfr_sync_edge #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         nrst_in,
	// Asynchronous levels
	input  wire logic [W-1:0] async_in,
	// Synchronised level and edges
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] rise_out,
	output logic      [W-1:0] fall_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] last_reg;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_reg  <= '1;
			level_out <= '1;
			last_reg  <= '1;
		end else begin
			meta_reg  <= async_in;
			level_out <= meta_reg;
			last_reg  <= level_out;
		end
	end

	assign rise_out = level_out & ~last_reg;
	assign fall_out = ~level_out & last_reg;
endmodule
`default_nettype wire

// ### verilog/sfr_host.sv
// Host end: makes the serial clock and chip select and runs read commands
`timescale 1ns/1ps
`default_nettype none
module sfr_host #(
	parameter int SCLK_HALF = sfr_pkg::SCLK_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	// Serial link
	sfr_link_if.host         lk,
	// Command request
	input  wire logic        cmd_valid_in,
	input  wire logic [7:0]  cmd_opcode_in,
	input  wire logic [23:0] cmd_addr_in,
	input  wire logic [15:0] cmd_len_in,
	input  wire logic        dummy_count_select_in,
	input  wire logic        wp_level_in,
	output logic             cmd_ready_out,
	// Read answer
	output logic [7:0]       rd_data_out,
	output logic             rd_valid_out,
	output logic             done_out
);
	typedef enum logic [5:0] {
		H_IDLE  = 6'h01,
		H_CMD   = 6'h02,
		H_ADDR  = 6'h04,
		H_DUMMY = 6'h08,
		H_DATA  = 6'h10,
		H_END   = 6'h20
	} sfr_host_state_t;

	sfr_host_state_t   state_reg;
	sfr_pkg::sfr_cmd_t cmd_reg;
	logic [7:0]        op_reg;
	logic [23:0]       sh_reg;
	logic [23:0]       in_next;
	logic [7:0]        in_reg;
	logic [4:0]        cnt_reg;
	logic [3:0]        hold_reg;
	logic [15:0]       len_reg;
	logic [4:0]        div_reg;
	logic [3:0]        io_s;
	logic [3:0]        ctl_oe_n;
	logic [3:0]        ctl_io;
	logic              rise_t;
	logic              fall_t;

	// ************************************************
	// Input synchronisation and clock divider
	// ************************************************
	sfr_sync_edge #(
		.W(4)
	) u_sync (
		.core_clk_in(core_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (lk.io_level),
		.level_out  (io_s),
		.rise_out   (),
		.fall_out   ()
	);

	assign rise_t  = (state_reg != H_IDLE) && (div_reg == 5'(SCLK_HALF - 1));
	assign fall_t  = (state_reg != H_IDLE) && (div_reg == 5'(2 * SCLK_HALF - 1));
	assign in_next = sfr_pkg::sfr_shift_in({16'h0000, in_reg}, io_s, cmd_reg.data_lw, 1'b1);
	// Quad commands hand io2 and io3 over as data lines; otherwise they hold pin and hold levels
	assign ctl_oe_n = cmd_reg.needs_qe ? 4'hC : 4'h0;
	assign ctl_io   = {1'b1, wp_level_in, 2'h0};

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_reg <= 5'h00;
			lk.sclk <= 1'b0;
		end else begin
			div_reg <= ((state_reg == H_IDLE && cmd_ready_out) || fall_t) ? 5'h00 : div_reg + 5'h01;
			lk.sclk <= rise_t ? 1'b1 : (fall_t ? 1'b0 : lk.sclk);
		end
	end

	// ************************************************
	// Command sequencer
	// ************************************************
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg     <= H_IDLE;
			cmd_reg       <= '0;
			op_reg        <= 8'h00;
			sh_reg        <= 24'h000000;
			in_reg        <= 8'h00;
			cnt_reg       <= 5'h00;
			hold_reg      <= 4'h0;
			len_reg       <= 16'h0000;
			lk.cs_n       <= 1'b1;
			lk.host_io    <= 4'h0;
			lk.host_oe_n  <= 4'hF;
			cmd_ready_out <= 1'b1;
			rd_data_out   <= 8'h00;
			rd_valid_out  <= 1'b0;
			done_out      <= 1'b0;
		end else begin
			rd_valid_out <= 1'b0;
			done_out     <= 1'b0;
			if (state_reg == H_IDLE) begin
				if (!cmd_ready_out) begin
					// Lines stay released a half period so the device floats before the next frame
					if (div_reg == 5'(SCLK_HALF - 1)) begin
						cmd_ready_out <= 1'b1;
					end
				end else if (cmd_valid_in) begin
					cmd_reg       <= sfr_pkg::sfr_decode(cmd_opcode_in, dummy_count_select_in);
					op_reg        <= cmd_opcode_in;
					sh_reg        <= {cmd_opcode_in[6:0], 17'h00000};
					len_reg       <= (cmd_len_in == 16'h0000) ? 16'h0001 : cmd_len_in;
					cnt_reg       <= sfr_pkg::CMD_BITS - 5'h01;
					lk.cs_n       <= 1'b0;
					lk.host_io    <= {ctl_io[3:1], cmd_opcode_in[7]};
					lk.host_oe_n  <= 4'h2;
					cmd_ready_out <= 1'b0;
					state_reg     <= H_CMD;
				end
			end else if (rise_t) begin
				cnt_reg <= cnt_reg - 5'h01;
				unique case (state_reg)
					H_CMD: if (cnt_reg == 5'h00) begin
						sh_reg    <= cmd_addr_in;
						cnt_reg   <= sfr_pkg::sfr_cycles(cmd_reg.addr_lw, sfr_pkg::ADDR_BITS) - 5'h01;
						state_reg <= (!cmd_reg.ok || op_reg == sfr_pkg::OP_WRITE_ENABLE_CMD) ? H_END : H_ADDR;
					end
					H_ADDR: if (cnt_reg == 5'h00) begin
						hold_reg  <= (cmd_reg.addr_lw == 2'h0) ? cmd_reg.dummy : sfr_pkg::DUMMY_HELD;
						cnt_reg   <= (cmd_reg.dummy == 4'h0) ?
							sfr_pkg::sfr_cycles(cmd_reg.data_lw, sfr_pkg::BYTE_BITS) - 5'h01 :
							{1'b0, cmd_reg.dummy} - 5'h01;
						state_reg <= (cmd_reg.dummy == 4'h0) ? H_DATA : H_DUMMY;
					end
					H_DUMMY: if (cnt_reg == 5'h00) begin
						cnt_reg   <= sfr_pkg::sfr_cycles(cmd_reg.data_lw, sfr_pkg::BYTE_BITS) - 5'h01;
						state_reg <= H_DATA;
					end
					H_DATA: begin
						in_reg <= in_next[7:0];
						if (cnt_reg == 5'h00) begin
							rd_data_out  <= in_next[7:0];
							rd_valid_out <= 1'b1;
							len_reg      <= len_reg - 16'h0001;
							cnt_reg      <= sfr_pkg::sfr_cycles(cmd_reg.data_lw, sfr_pkg::BYTE_BITS) - 5'h01;
							state_reg    <= (len_reg == 16'h0001) ? H_END : H_DATA;
						end
					end
					H_END: cnt_reg <= 5'h00;
					default: state_reg <= H_END;
				endcase
			end else if (fall_t) begin
				unique case (state_reg)
					H_CMD: begin
						lk.host_io <= {ctl_io[3:1], sh_reg[23]};
						sh_reg     <= sh_reg << 1;
					end
					H_ADDR: begin
						lk.host_oe_n <= ~sfr_pkg::sfr_lanes(cmd_reg.addr_lw) & ~(ctl_oe_n ^ 4'hC) & 4'hE | 4'h0;
						lk.host_io   <= (cmd_reg.addr_lw == 2'h0) ? {ctl_io[3:1], sh_reg[23]} :
							(cmd_reg.addr_lw == 2'h1) ? {ctl_io[3:2], sh_reg[23:22]} : sh_reg[23:20];
						sh_reg       <= sh_reg << (5'h01 << cmd_reg.addr_lw);
					end
					H_DUMMY: begin
						// First dummies hold zero on io1 and io0, with hold and pin levels on io3 and io2, so the pattern cannot toggle
						lk.host_io <= ctl_io;
						if (hold_reg != 4'h0) begin
							hold_reg     <= hold_reg - 4'h1;
						end else begin
							lk.host_oe_n <= sfr_pkg::sfr_lanes(cmd_reg.addr_lw) | ctl_oe_n;
						end
					end
					H_DATA: begin
						lk.host_io   <= ctl_io;
						lk.host_oe_n <= ((cmd_reg.data_lw == 2'h0) ? 4'h2 : sfr_pkg::sfr_lanes(cmd_reg.data_lw)) | ctl_oe_n;
					end
					H_END: begin
						lk.cs_n       <= 1'b1;
						lk.host_oe_n  <= 4'hF;
						done_out      <= 1'b1;
						state_reg     <= H_IDLE;
					end
					default: state_reg <= H_END;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/sfr_link_properties.sv
// Timing checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module sfr_link_properties (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       nrst_in,
	// Link signals
	input wire logic       sclk,
	input wire logic       cs_n,
	input wire logic [3:0] host_io,
	input wire logic [3:0] host_oe_n,
	input wire logic [3:0] dev_io,
	input wire logic [3:0] dev_oe_n
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	idle_float_a: assert property (cs_n [*6] |-> dev_oe_n == 4'hF)
		else $error("device drives while deselected");
	release_fast_a: assert property ($rose(cs_n) |-> ##[1:6] dev_oe_n == 4'hF)
		else $error("device slow to release lines");
	no_clash_a: assert property ((~host_oe_n & ~dev_oe_n) == 4'h0)
		else $error("both ends drive one line");
	clk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("clock moves outside a frame");
	rise_sel_a: assert property ($rose(sclk) |-> !cs_n)
		else $error("clock rises while deselected");
	high_time_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("clock high time wrong");
	frame_start_a: assert property ($fell(cs_n) |-> host_oe_n[1] && !host_oe_n[0])
		else $error("opcode line not driven at frame start");
	dev_shift_a: assert property ($changed(dev_io) && dev_oe_n != 4'hF |-> !sclk)
		else $error("device data changed while clock high");
	host_hold_a: assert property (sclk && $past(sclk) |-> $stable(host_io))
		else $error("host data changed while clock high");
endmodule
`default_nettype wire

// ### verification/tb_serial_flash_read_and_protect.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_read_and_protect;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ld_we = 1'b0;
	logic [7:0]  ld_a = 8'h00;
	logic [7:0]  ld_d = 8'h00;
	logic        write_in_progress_flag = 1'b0;
	logic        lock = 1'b0;
	logic        qe = 1'b0;
	logic        dc = 1'b0;
	logic        wclr = 1'b0;
	logic        vld = 1'b0;
	logic [7:0]  opc = 8'h00;
	logic [23:0] adr = 24'h000000;
	logic [15:0] len = 16'h0001;
	logic        wp = 1'b1;
	logic        write_enable_latch, hwp, swp, swa, brj, rdy, rdv, done, hp, br;
	logic [7:0]  rdd;
	logic [7:0]  got [$];
	logic [7:0]  rd_ops [5] = '{sfr_pkg::OP_FAST, sfr_pkg::OP_DOUT, sfr_pkg::OP_DIO, sfr_pkg::OP_QOUT, sfr_pkg::OP_QIO};
	int          errors = 0;
	int          total_checks = 0;

	always #5 clk = ~clk;

	sfr_link_if lk ();
	sfr_host u_sfr_host (.core_clk_in(clk), .nrst_in(nrst), .lk(lk), .cmd_valid_in(vld), .cmd_opcode_in(opc),
		.cmd_addr_in(adr), .cmd_len_in(len), .dummy_count_select_in(dc), .wp_level_in(wp), .cmd_ready_out(rdy),
		.rd_data_out(rdd), .rd_valid_out(rdv), .done_out(done));
	sfr_device #(.ADDR_W(8)) u_sfr_device (.core_clk_in(clk), .nrst_in(nrst), .lk(lk), .load_we_in(ld_we),
		.load_addr_in(ld_a), .load_data_in(ld_d), .write_in_progress_flag_in(write_in_progress_flag), .protect_lock_bit_in(lock),
		.quad_enable_bit_in(qe), .dummy_count_select_in(dc), .wel_clear_in(wclr), .write_enable_latch_out(write_enable_latch),
		.hardware_protection_out(hwp), .software_protection_out(swp), .status_write_allowed_out(swa),
		.busy_rejected_out(brj));
	sfr_link_properties u_sfr_link_properties (.core_clk_in(clk), .nrst_in(nrst), .sclk(lk.sclk), .cs_n(lk.cs_n),
		.host_io(lk.host_io), .host_oe_n(lk.host_oe_n), .dev_io(lk.dev_io), .dev_oe_n(lk.dev_oe_n));

	// ****************
	// Helpers
	// ****************
	function automatic logic [7:0] mv(input logic [7:0] a);
		return a ^ 8'hA5;
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input bit ok, input string m);
		total_checks++;
		if (!ok) begin
			errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// One whole frame; collects bytes and whether the hardware protection and busy rejected outputs were high meanwhile
	task automatic run(input logic [7:0] op, input logic [23:0] a, input int n);
		int k;
		got.delete();
		hp = 1'b0;
		br = 1'b0;
		opc = op;
		adr = a;
		len = n[15:0];
		// The host keeps its lines released for a while after a frame
		while (rdy !== 1'b1) begin
			@(negedge clk);
		end
		vld = 1'b1;
		@(negedge clk);
		vld = 1'b0;
		chk(rdy === 1'b0, "request not taken");
		for (k = 0; k < 5000 && done !== 1'b1; k++) begin
			@(negedge clk);
			if (rdv === 1'b1) begin
				got.push_back(rdd);
			end
			hp = hp | (hwp === 1'b1);
			br = br | (brj === 1'b1);
		end
		chk(k < 5000, "frame never ended");
	endtask

	// Floating lines read back as all ones
	task automatic expect_bytes(input logic [7:0] a, input int n, input bit flt);
		chk(got.size() == n, "byte count");
		foreach (got[i]) chk(got[i] === (flt ? 8'hFF : mv(a + i[7:0])), "read data");
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_basic();
		run(sfr_pkg::OP_READ, 24'h0000FE, 3);
		expect_bytes(8'hFE, 3, 1'b0);
		$display("plain read across the top address done");
	endtask

	task automatic t_modes();
		logic [7:0] a;
		qe = 1'b1;
		for (int d = 0; d < 2; d++) begin
			dc = d[0];
			foreach (rd_ops[i]) begin
				a = 8'h30 + 8'(i * 16 + d);
				run(rd_ops[i], {16'h0000, a}, 2);
				expect_bytes(a, 2, 1'b0);
			end
		end
		qe = 1'b0;
		dc = 1'b0;
		$display("all read modes and dummy counts done");
	endtask

	task automatic t_busy();
		write_in_progress_flag = 1'b1;
		qe = 1'b1;
		foreach (rd_ops[i]) begin
			run(rd_ops[i], 24'h000040, 1);
			chk(br === 1'b1, "busy refusal missing");
			expect_bytes(8'h40, 1, 1'b1);
		end
		run(sfr_pkg::OP_READ, 24'h000041, 1);
		chk(br === 1'b0, "plain read refused");
		expect_bytes(8'h41, 1, 1'b0);
		write_in_progress_flag = 1'b0;
		qe = 1'b0;
		$display("reads during internal cycle done");
	endtask

	task automatic t_protect();
		logic [3:0] tbl [5] = '{4'b0000, 4'b1001, 4'b1100, 4'b1010, 4'b1001};
		foreach (tbl[i]) begin
			{lock, wp, qe} = tbl[i][3:1];
			run(sfr_pkg::OP_WRITE_ENABLE_CMD, 24'h000000, 1);
			chk(hp === tbl[i][0], "protection mode");
			chk(write_enable_latch === 1'b1, "latch not set");
			if (i == 0) begin
				chk(swa === 1'b1 && swp === 1'b1, "status write blocked");
			end
			wclr = 1'b1;
			@(negedge clk);
			wclr = 1'b0;
			@(negedge clk);
			chk(write_enable_latch === 1'b0, "latch not cleared");
		end
		{lock, wp, qe} = 3'b010;
		$display("protection modes done");
	endtask

	initial begin
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		for (int a = 0; a < 256; a++) begin
			ld_we = 1'b1;
			ld_a = a[7:0];
			ld_d = mv(a[7:0]);
			@(negedge clk);
		end
		ld_we = 1'b0;
		repeat (4) @(negedge clk);
		t_basic();
		t_modes();
		t_busy();
		t_protect();
		wrap_up();
	end

	initial begin
		#800us;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
`default_nettype wire
